// ### src/baud_frac_pkg.sv
// Purpose: Shared constants for the fractional baud generator and interrupt level block
// Assumes: One clock, byte-wide register port
// Notes: Register indices are addressed on i_reg_addr

package baud_frac_pkg;
  // --------------------------------------------------------------------------
  // Register indices
  // --------------------------------------------------------------------------
  localparam logic [2:0] ADDR_DIV_LOW = 3'h0;
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h1;
  localparam logic [2:0] ADDR_DIV_FRAC = 3'h2;
  localparam logic [2:0] ADDR_MODEM_CTRL = 3'h3;
  localparam logic [2:0] ADDR_OCTO_SEL = 3'h4;
  localparam logic [2:0] ADDR_QUAD_SEL = 3'h5;
  localparam logic [2:0] ADDR_FIFO_CTRL = 3'h6;
  localparam logic [2:0] ADDR_STATUS = 3'h7;

  // --------------------------------------------------------------------------
  // Reset values and fields
  // --------------------------------------------------------------------------
  localparam logic [7:0] RST_DIV_LOW = 8'h01;
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic [3:0] RST_DIV_FRAC = 4'h0;
  localparam logic [7:0] RST_MODEM_CTRL = 8'h00;
  localparam logic [7:0] RST_SEL = 8'h00;
  localparam logic [7:0] RST_FIFO_CTRL = 8'h00;
  localparam logic [7:0] SEL_ON = 8'hff;
  localparam logic [7:0] SEL_OFF = 8'h00;
  localparam int PRESCALE_BIT = 7;
  localparam int FIFO_EN_BIT = 0;
  localparam int FRAC_W = 4;

  // --------------------------------------------------------------------------
  // Timing counts
  // --------------------------------------------------------------------------
  localparam logic [1:0] PRESCALE_DIV4_LAST = 2'h3;
  localparam logic [4:0] MULT_16X = 5'h10;
  localparam logic [4:0] MULT_8X = 5'h08;
  localparam logic [4:0] MULT_4X = 5'h04;

  typedef enum logic [1:0] {
    SAMPLE_16X,
    SAMPLE_8X,
    SAMPLE_4X
  } sample_mode_t;
endpackage : baud_frac_pkg

// ### src/baud_frac_irq.sv
// Purpose: One channel's fractional baud generator and interrupt level logic
// Assumes: All inputs synchronous to i_clk; i_clk is the oscillator clock
// Notes: Divisor writes take effect at the next sampling period boundary

// What this block does
// R1 - FIFO off: tx level follows holding byte
// R2 - FIFO on: tx level high above trigger
// R3 - Half-duplex: tx level low when transmitter empty
// R4 - Rx level: high no data/below trigger
// R5 - Oscillator clock drives all logic here
// R6 - Own prescaler and baud generator per channel
// R7 - Modem control top bit selects divide-by-4
// R8 - Divide prescaled clock by integer plus sixteenths
// R9 - Sampling tick times tx and rx
// R10 - Reset divisor to exactly one
// R11 - Software programs divisor for real rate
// R12 - High byte and low byte form integer
// R13 - Only four fraction bits, n sixteenths
// R14 - Sampling select registers pick 16x/8x/4x
// R15 - 8x doubles, 4x quadruples data rate
// R16 - Only odd fractions jitter in 8x
// R17 - Software rounds fraction to nearest sixteenth
// R18 - Bit time is 16/8/4 sampling periods
// R19 - Dedicated registers choose 8x or 4x
// R20 - Fraction by stretching spread sampling periods
// R21 - Divisor writes apply at next period
module baud_frac_irq
  import baud_frac_pkg::*;
#(
  parameter int DIV_INT_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_reg_wr,
  input wire logic [2:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_tx_holding_full,
  input wire logic i_tx_fifo_above_trig,
  input wire logic i_tx_fifo_empty,
  input wire logic i_tx_all_empty,
  input wire logic i_half_duplex,
  input wire logic i_rx_byte_held,
  input wire logic i_rx_fifo_above_trig,
  output logic o_sample_tick,
  output logic o_bit_tick,
  output logic o_tx_irq_level,
  output logic o_rx_irq_level
);
  import baud_frac_pkg::*;

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic [7:0] divisor_low_byte;
  logic [7:0] divisor_high_byte;
  logic [FRAC_W-1:0] divisor_fraction;
  logic [7:0] modem_control_reg;
  logic [7:0] octo_sampling_select;
  logic [7:0] quad_sampling_select;
  logic [7:0] fifo_control_reg;
  logic [7:0] next_divisor_low_byte;
  logic [7:0] next_divisor_high_byte;
  logic [FRAC_W-1:0] next_divisor_fraction;
  logic [7:0] next_modem_control_reg;
  logic [7:0] next_octo_sampling_select;
  logic [7:0] next_quad_sampling_select;
  logic [7:0] next_fifo_control_reg;

  always_comb begin
    next_divisor_low_byte = divisor_low_byte;
    next_divisor_high_byte = divisor_high_byte;
    next_divisor_fraction = divisor_fraction;
    next_modem_control_reg = modem_control_reg;
    next_octo_sampling_select = octo_sampling_select;
    next_quad_sampling_select = quad_sampling_select;
    next_fifo_control_reg = fifo_control_reg;
    if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_DIV_LOW: next_divisor_low_byte = i_reg_wdata;
        ADDR_DIV_HIGH: next_divisor_high_byte = i_reg_wdata;
        ADDR_DIV_FRAC: next_divisor_fraction = i_reg_wdata[FRAC_W-1:0]; // R13
        ADDR_MODEM_CTRL: next_modem_control_reg = i_reg_wdata;
        ADDR_OCTO_SEL: next_octo_sampling_select = i_reg_wdata; // R19
        ADDR_QUAD_SEL: next_quad_sampling_select = i_reg_wdata; // R19
        ADDR_FIFO_CTRL: next_fifo_control_reg = i_reg_wdata;
        // Status index is read-only, so its writes fall through to default
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      divisor_low_byte <= RST_DIV_LOW; // R10
      divisor_high_byte <= RST_DIV_HIGH; // R10
      divisor_fraction <= RST_DIV_FRAC; // R10
      modem_control_reg <= RST_MODEM_CTRL;
      octo_sampling_select <= RST_SEL;
      quad_sampling_select <= RST_SEL;
      fifo_control_reg <= RST_FIFO_CTRL;
    end else if (i_ce) begin
      divisor_low_byte <= next_divisor_low_byte;
      divisor_high_byte <= next_divisor_high_byte;
      divisor_fraction <= next_divisor_fraction;
      modem_control_reg <= next_modem_control_reg;
      octo_sampling_select <= next_octo_sampling_select;
      quad_sampling_select <= next_quad_sampling_select;
      fifo_control_reg <= next_fifo_control_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Sampling mode decode
  // --------------------------------------------------------------------------
  sample_mode_t sample_mode;
  logic [4:0] sample_mult;

  // Reserved and partial patterns fall back to 16x, the safest rate
  always_comb begin
    sample_mode = SAMPLE_16X;
    if (octo_sampling_select == SEL_ON && quad_sampling_select == SEL_OFF) begin
      sample_mode = SAMPLE_8X; // R14
    end else if (octo_sampling_select == SEL_OFF && quad_sampling_select == SEL_ON) begin
      sample_mode = SAMPLE_4X; // R14
    end
    case (sample_mode)
      SAMPLE_8X: sample_mult = MULT_8X; // R15
      SAMPLE_4X: sample_mult = MULT_4X; // R15
      default: sample_mult = MULT_16X;
    endcase
  end

  // --------------------------------------------------------------------------
  // Prescaler
  // --------------------------------------------------------------------------
  logic [1:0] pre_cnt;
  logic [1:0] next_pre_cnt;
  logic pre_tick;

  // Count parks at zero when bypassed, so divide-by-4 always starts a full group
  always_comb begin
    next_pre_cnt = 2'h0;
    pre_tick = 1'b1; // R7
    if (modem_control_reg[PRESCALE_BIT]) begin
      next_pre_cnt = pre_cnt + 2'h1;
      pre_tick = (pre_cnt == PRESCALE_DIV4_LAST); // R7
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_cnt <= 2'h0;
    end else if (i_ce) begin
      pre_cnt <= next_pre_cnt;
    end
  end

  // --------------------------------------------------------------------------
  // Baud generator
  // --------------------------------------------------------------------------
  logic [DIV_INT_W:0] period_cnt;
  logic [DIV_INT_W:0] next_period_cnt;
  logic [DIV_INT_W:0] period_len;
  logic [DIV_INT_W:0] next_period_len;
  logic [FRAC_W-1:0] phase;
  logic [FRAC_W-1:0] next_phase;
  logic [FRAC_W-1:0] phase_inc;
  logic [FRAC_W-1:0] phase_rev;
  logic [3:0] samp_cnt;
  logic [3:0] next_samp_cnt;
  logic [DIV_INT_W-1:0] div_int;
  logic period_end;
  logic stretch;
  logic next_sample_tick;
  logic next_bit_tick;

  // Bit reversal of the phase spreads stretched periods evenly over sixteen
  genvar gi;
  generate
    for (gi = 0; gi < FRAC_W; gi++) begin : g_rev
      assign phase_rev[gi] = phase_inc[FRAC_W-1-gi];
    end
  endgenerate

  assign phase_inc = phase + 4'h1;

  // Length is latched at each boundary, so a divisor write never cuts a running period
  always_comb begin
    div_int = {divisor_high_byte, divisor_low_byte}; // R12
    // Zero integer divisor is treated as one to keep the tick alive
    if (div_int == '0) begin
      div_int = {{(DIV_INT_W-1){1'b0}}, 1'b1};
    end
    period_end = pre_tick && (period_cnt + 1'b1 >= period_len); // R8
    next_period_cnt = period_cnt;
    next_period_len = period_len;
    next_phase = phase;
    stretch = 1'b0;
    next_samp_cnt = samp_cnt;
    next_bit_tick = 1'b0;
    next_sample_tick = 1'b0;
    if (pre_tick) begin
      next_period_cnt = period_cnt + 1'b1;
    end
    if (period_end) begin
      next_sample_tick = 1'b1; // R9
      next_period_cnt = '0;
      next_phase = phase_inc;
      stretch = (phase_rev < divisor_fraction); // R20 R16
      next_period_len = {1'b0, div_int} + {{DIV_INT_W{1'b0}}, stretch}; // R21 R8
      if ({1'b0, samp_cnt} + 5'h01 >= sample_mult) begin
        next_samp_cnt = 4'h0;
        next_bit_tick = 1'b1; // R18
      end else begin
        next_samp_cnt = samp_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      period_cnt <= '0;
      period_len <= {{DIV_INT_W{1'b0}}, 1'b1};
      phase <= 4'h0;
      samp_cnt <= 4'h0;
      o_sample_tick <= 1'b0;
      o_bit_tick <= 1'b0;
    end else if (i_ce) begin // R5 R6
      period_cnt <= next_period_cnt;
      period_len <= next_period_len;
      phase <= next_phase;
      samp_cnt <= next_samp_cnt;
      o_sample_tick <= next_sample_tick;
      o_bit_tick <= next_bit_tick;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt levels
  // --------------------------------------------------------------------------
  logic next_tx_irq_level;
  logic next_rx_irq_level;
  logic fifo_en;

  // Levels are registered, so they trail their inputs by one clock
  always_comb begin
    fifo_en = fifo_control_reg[FIFO_EN_BIT];
    if (!fifo_en) begin
      next_tx_irq_level = i_tx_holding_full; // R1
      next_rx_irq_level = !i_rx_byte_held; // R4
    end else begin
      next_rx_irq_level = !i_rx_fifo_above_trig; // R4
      if (i_half_duplex) begin
        next_tx_irq_level = i_tx_fifo_above_trig && !i_tx_all_empty; // R3
      end else begin
        next_tx_irq_level = i_tx_fifo_above_trig && !i_tx_fifo_empty; // R2
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_tx_irq_level <= 1'b0;
      o_rx_irq_level <= 1'b1;
    end else if (i_ce) begin
      o_tx_irq_level <= next_tx_irq_level;
      o_rx_irq_level <= next_rx_irq_level;
    end
  end

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  logic [7:0] next_reg_rdata;

  // Status shows live mode, fraction phase and both levels
  always_comb begin
    case (i_reg_addr)
      ADDR_DIV_LOW: next_reg_rdata = divisor_low_byte;
      ADDR_DIV_HIGH: next_reg_rdata = divisor_high_byte;
      ADDR_DIV_FRAC: next_reg_rdata = {4'h0, divisor_fraction}; // R13
      ADDR_MODEM_CTRL: next_reg_rdata = modem_control_reg;
      ADDR_OCTO_SEL: next_reg_rdata = octo_sampling_select;
      ADDR_QUAD_SEL: next_reg_rdata = quad_sampling_select;
      ADDR_FIFO_CTRL: next_reg_rdata = fifo_control_reg;
      ADDR_STATUS: next_reg_rdata = {phase, sample_mode, o_rx_irq_level, o_tx_irq_level};
      default: next_reg_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 8'h00;
    end else if (i_ce) begin
      o_reg_rdata <= next_reg_rdata;
    end
  end
endmodule : baud_frac_irq

// ### testbench/baud_frac_irq_monitor.sv
// Purpose: Port checks for baud ticks and irq levels
// Assumes: One clock, async active-low reset
// Notes: Mirrors the FIFO enable bit from writes
module baud_frac_irq_monitor (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_reg_wr,
  input wire logic [2:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_tx_holding_full,
  input wire logic i_tx_fifo_above_trig,
  input wire logic i_tx_fifo_empty,
  input wire logic i_tx_all_empty,
  input wire logic i_half_duplex,
  input wire logic i_rx_byte_held,
  input wire logic i_rx_fifo_above_trig,
  input wire logic o_sample_tick,
  input wire logic o_bit_tick,
  input wire logic o_tx_irq_level,
  input wire logic o_rx_irq_level
);
  timeunit 1ns;
  timeprecision 1ps;
  import baud_frac_pkg::*;
  logic fifo_on;
  logic next_fifo_on;
  logic ce_q;
  logic [3:0] span;
  logic [3:0] next_span;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // ----
  // Helper state
  // ----
  always_comb begin
    next_fifo_on = fifo_on;
    next_span = span;
    if (i_ce && i_reg_wr && i_reg_addr == ADDR_FIFO_CTRL) begin
      next_fifo_on = i_reg_wdata[FIFO_EN_BIT];
    end
    // Held ticks during a freeze are not new ticks
    if (ce_q && o_bit_tick) begin
      next_span = 4'h0;
    end else if (ce_q && o_sample_tick) begin
      next_span = span + 4'h1;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fifo_on <= 1'b0;
      ce_q <= 1'b0;
      span <= 4'h0;
    end else begin
      fifo_on <= next_fifo_on;
      ce_q <= i_ce;
      span <= next_span;
    end
  end
  a_tx_byte_level: assert property (i_ce && !fifo_on |=> o_tx_irq_level == $past(i_tx_holding_full))
    else $error("tx level wrong with fifo off");
  a_tx_fifo_level: assert property (i_ce && fifo_on && !i_half_duplex |=>
    o_tx_irq_level == ($past(i_tx_fifo_above_trig) && !$past(i_tx_fifo_empty))) else $error("tx level wrong");
  a_tx_half_level: assert property (i_ce && fifo_on && i_half_duplex |=>
    o_tx_irq_level == ($past(i_tx_fifo_above_trig) && !$past(i_tx_all_empty)))
    else $error("tx level wrong in half duplex");
  a_rx_level_map: assert property (i_ce |=> o_rx_irq_level ==
    ($past(fifo_on) ? !$past(i_rx_fifo_above_trig) : !$past(i_rx_byte_held))) else $error("rx level wrong");
  a_bit_on_sample: assert property (o_bit_tick |-> o_sample_tick)
    else $error("bit tick without sample tick");
  a_bit_span_max: assert property (ce_q && o_sample_tick && span == 4'hf |-> o_bit_tick)
    else $error("bit longer than sixteen ticks");
  a_freeze_hold: assert property (!i_ce |=> $stable(o_sample_tick) && $stable(o_tx_irq_level))
    else $error("outputs moved while frozen");
  a_frac_top_zero: assert property (i_ce && i_reg_addr == ADDR_DIV_FRAC |=> o_reg_rdata[7:4] == 4'h0)
    else $error("fraction upper bits not zero");
  cover property (o_bit_tick);
  cover property (fifo_on && i_half_duplex && o_tx_irq_level);
  cover property (!i_ce);
endmodule : baud_frac_irq_monitor

bind baud_frac_irq baud_frac_irq_monitor u_mon (.i_clk, .i_rst_b, .i_ce, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
  .o_reg_rdata, .i_tx_holding_full, .i_tx_fifo_above_trig, .i_tx_fifo_empty, .i_tx_all_empty, .i_half_duplex,
  .i_rx_byte_held, .i_rx_fifo_above_trig, .o_sample_tick, .o_bit_tick, .o_tx_irq_level, .o_rx_irq_level);

// ### testbench/host_model.sv
// Purpose: Host processor driving the register port
// Assumes: Writes one cycle each, reads one cycle late
// Notes: Signals change 1 ns after the rising edge
module host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic [2:0] o_addr,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_wr = 1'b0;
    o_addr = 3'h0;
    o_wdata = 8'h00;
  end
  // Divisor must be set before real traffic
  task write_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk) #1;
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk) #1;
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask : write_reg
  task read_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk) #1;
    o_addr = a;
    @(posedge i_clk) #1;
    d = i_rdata;
  endtask : read_reg
endmodule : host_model

// ### testbench/uart_fractional_baud_and_irq_level_test.sv
// Purpose: Directed test of baud ticks and irq levels
// Assumes: 250 MHz clock, reset held three cycles
// Notes: Tick periods measured in clocks
module uart_fractional_baud_and_irq_level_test;
  timeunit 1ns;
  timeprecision 1ps;
  import baud_frac_pkg::*;
  logic clk = 0, rst_b = 0, ce = 1, wr, s_tk, b_tk, tx_l, rx_l;
  logic [2:0] adr;
  logic [7:0] wd, rd, v;
  logic [6:0] lv_in = 7'h0;
  int errors = 0, checks_done = 0, n, k;
  logic [7:0] md [4][2] = '{'{8'h00, 8'h00}, '{8'hff, 8'h00}, '{8'h00, 8'hff}, '{8'hff, 8'hff}};
  int mult [4] = '{16, 8, 4, 16};
  logic [1:0] mcode [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  always #2 clk = ~clk;
  host_model u_host (.i_clk(clk), .i_rdata(rd), .o_wr(wr), .o_addr(adr), .o_wdata(wd));
  baud_frac_irq DUT (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_reg_wr(wr), .i_reg_addr(adr),
    .i_reg_wdata(wd), .o_reg_rdata(rd), .i_tx_holding_full(lv_in[6]), .i_tx_fifo_above_trig(lv_in[5]),
    .i_tx_fifo_empty(lv_in[4]), .i_tx_all_empty(lv_in[3]), .i_half_duplex(lv_in[2]), .i_rx_byte_held(lv_in[1]),
    .i_rx_fifo_above_trig(lv_in[0]), .o_sample_tick(s_tk), .o_bit_tick(b_tk), .o_tx_irq_level(tx_l),
    .o_rx_irq_level(rx_l));
  task check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task rd_chk(input logic [2:0] a, input logic [7:0] e);
    u_host.read_reg(a, v);
    check(v, e);
  endtask : rd_chk
  // Sum of 16 consecutive sample periods, in clocks
  task gaps(output int c);
    c = 0;
    do @(posedge clk) #1; while (s_tk !== 1'b1);
    repeat (16) begin
      do begin @(posedge clk) #1; c++; end while (s_tk !== 1'b1);
    end
  endtask : gaps
  task bits(output int c);
    do @(posedge clk) #1; while (b_tk !== 1'b1);
    c = 0;
    do begin @(posedge clk) #1; c += (s_tk === 1'b1); end while (b_tk !== 1'b1);
  endtask : bits
  // Clocks from one bit tick to the next
  task bit_clocks(output int c);
    do @(posedge clk) #1; while (b_tk !== 1'b1);
    c = 0;
    do begin @(posedge clk) #1; c++; end while (b_tk !== 1'b1);
  endtask : bit_clocks
  task lv(input logic [6:0] in, input logic [1:0] e);
    lv_in = in;
    repeat (2) @(posedge clk) #1;
    check({tx_l, rx_l}, e);
  endtask : lv
  task stop_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    errors++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_b = 1;
    rd_chk(ADDR_DIV_LOW, 8'h01);
    rd_chk(ADDR_DIV_HIGH, 8'h00);
    rd_chk(ADDR_DIV_FRAC, 8'h00);
    gaps(n);
    check(n, 16);
    u_host.write_reg(ADDR_DIV_FRAC, 8'hf5);
    rd_chk(ADDR_DIV_FRAC, 8'h05);
    // Rate chosen so divisor is 3 and 5/16
    u_host.write_reg(ADDR_DIV_LOW, 8'h03);
    gaps(n);
    gaps(n);
    check(n, 53);
    u_host.write_reg(ADDR_MODEM_CTRL, 8'h80);
    rd_chk(ADDR_MODEM_CTRL, 8'h80);
    gaps(n);
    gaps(n);
    check(n, 212);
    u_host.write_reg(ADDR_MODEM_CTRL, 8'h00);
    for (k = 0; k < 4; k++) begin
      u_host.write_reg(ADDR_OCTO_SEL, md[k][0]);
      u_host.write_reg(ADDR_QUAD_SEL, md[k][1]);
      bits(n);
      bits(n);
      check(n, mult[k]);
      rd_chk(ADDR_QUAD_SEL, md[k][1]);
      u_host.read_reg(ADDR_STATUS, v);
      check(v[3:2], mcode[k]);
    end
    // Even fraction in 8x: every bit is 8 periods of 3 plus one stretch
    u_host.write_reg(ADDR_QUAD_SEL, 8'h00);
    u_host.write_reg(ADDR_DIV_FRAC, 8'h02);
    bit_clocks(n);
    bit_clocks(n);
    check(n, 25);
    bit_clocks(n);
    check(n, 25);
    u_host.write_reg(ADDR_DIV_FRAC, 8'h00);
    u_host.write_reg(ADDR_DIV_LOW, 8'h00);
    u_host.write_reg(ADDR_DIV_HIGH, 8'h01);
    rd_chk(ADDR_DIV_HIGH, 8'h01);
    gaps(n);
    gaps(n);
    check(n, 4096);
    lv(7'b1000000, 2'b11);
    lv(7'b0000010, 2'b00);
    u_host.write_reg(ADDR_FIFO_CTRL, 8'h01);
    rd_chk(ADDR_FIFO_CTRL, 8'h01);
    lv(7'b0100000, 2'b11);
    lv(7'b0110001, 2'b00);
    lv(7'b0101100, 2'b01);
    lv(7'b0100100, 2'b11);
    ce = 0;
    lv(7'b0000001, 2'b11);
    ce = 1;
    stop_test();
  end
endmodule : uart_fractional_baud_and_irq_level_test
